// ### periph_frame_regs.svh
// offsets, field positions, reset values and timing counts of the peripheral frame
`ifndef PERIPH_FRAME_REGS_SVH
`define PERIPH_FRAME_REGS_SVH

// ----------------------------------------------------------------
// address slots
// ----------------------------------------------------------------
`define PERIPH_BASE_ADDR      32'h4000_0000
`define PERIPH_SLOT_SIZE      32'h0000_1000
`define SLOT_OFF_BITS         12

// ----------------------------------------------------------------
// register offsets inside one slot
// ----------------------------------------------------------------
`define OFF_TASK_BASE         12'h000
`define OFF_SUBSCRIBE_BASE    12'h080
`define OFF_EVENT_BASE        12'h100
`define OFF_PUBLISH_BASE      12'h180
`define OFF_SHORTCUTS         12'h200
`define OFF_INT_ENABLE_MASK   12'h300
`define OFF_INT_ENABLE_SETTER 12'h304
`define OFF_INT_ENABLE_CLEARER 12'h308
`define OFF_ENABLE            12'h500
`define OFF_PIN_SELECT        12'h508

// ----------------------------------------------------------------
// fields, reset values, timing
// ----------------------------------------------------------------
`define HOOK_EN_BIT           31
`define ENABLE_BIT            0
`define TRIGGER_BIT           0
`define SHORTCUTS_RESET       32'h0000_0000
`define PIN_SELECT_RESET      32'h0000_001F
`define PIN_CONNECT_CYC       4

`endif

// ### periph_frame_pkg.sv
// types shared by the peripheral frame modules
`default_nettype none
package periph_frame_pkg;

    // pin select sequencer, gray coded along idle -> wait -> live
    typedef enum logic [1:0]
    {
        PIN_IDLE = 2'b00,
        PIN_WAIT = 2'b01,
        PIN_LIVE = 2'b11
    } pin_state_t;

    typedef logic [11:0] slot_off_t;

endpackage
`default_nettype wire

// ### pin_select_delay.sv
// delays a new pin selection by a fixed number of cycles before it drives the pin
`timescale 1ns/1ns
`include "periph_frame_regs.svh"
`default_nettype none
module pin_select_delay
    import periph_frame_pkg::*;
#(
    parameter int PIN_W = 5
)
(
    input  wire logic             sys_clk,   // system clock
    input  wire logic             reset_n,   // async reset
    input  wire logic             ce,        // clock enable
    input  wire logic             load,      // take sel_in
    input  wire logic [PIN_W-1:0] sel_in,    // new selection
    output logic      [PIN_W-1:0] pin_sel,   // selection in force
    output logic                  pin_live   // the last loaded selection is in force
);

    localparam logic [2:0] LOAD_CNT = 3'(`PIN_CONNECT_CYC - 1);

    if (PIN_W < 1 || PIN_W > 31)
    begin : g_bad_params
        $error("pin_select_delay: PIN_W out of range");
    end

    pin_state_t       state_r, state_nxt;
    logic [2:0]       cnt_r, cnt_nxt;
    logic [PIN_W-1:0] stage_r, stage_nxt;
    logic [PIN_W-1:0] sel_r, sel_nxt;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        stage_nxt = stage_r;
        sel_nxt   = sel_r;
        if (load)
        begin
            stage_nxt = sel_in;
            cnt_nxt   = LOAD_CNT;
            state_nxt = PIN_WAIT;
        end
        else
        begin
            case (state_r)
                PIN_IDLE: state_nxt = PIN_IDLE;
                PIN_WAIT:
                begin
                    if (cnt_r == 3'h0)
                    begin
                        sel_nxt   = stage_r;
                        state_nxt = PIN_LIVE;
                    end
                    else
                    begin
                        cnt_nxt = cnt_r - 3'h1;
                    end
                end
                PIN_LIVE: state_nxt = PIN_LIVE;
                default:  state_nxt = PIN_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= PIN_IDLE;
            cnt_r   <= 3'h0;
            stage_r <= PIN_W'(`PIN_SELECT_RESET);
            sel_r   <= PIN_W'(`PIN_SELECT_RESET);
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            stage_r <= stage_nxt;
            sel_r   <= sel_nxt;
        end
    end

    assign pin_sel  = sel_r;
    assign pin_live = (state_r == PIN_LIVE);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_pin_delay_four: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (ce && load) ##1 (ce && !load) [*4] |=> (pin_sel == $past(sel_in, 5)))
        else $error("pin selection not in force four cycles after write");

endmodule // pin_select_delay
`default_nettype wire

// ### periph_frame.sv
// register frame of one peripheral: tasks, events, shortcuts, hooks, interrupt, pin select
// ----------------------------------------------------------------
// How it works
// - each peripheral decodes its own 4 KB window
// - peripheral ID equals slot index above base
// - one interrupt line, index equals ID
// - main, set, clear aliases on consecutive words
// - ones set or clear bits, zeros ignored
// - alias reads return the main register
// - task fires on write one or signal
// - generated event sets its event register
// - only a software zero write clears event
// - new events still pulse while register is set
// - enabled shortcut fires its fixed task
// - one shortcut register, one bit each
// - each event maskable onto the interrupt
// - each event owns one mask bit position
// - set and clear aliases read the mask
// - publish and subscribe hooks per event, task
// - pin select stored while running, applied on next enable
// - new pin live four cycles after write
// - tasks and events ignored while disabled
// ----------------------------------------------------------------
`timescale 1ns/1ns
`include "periph_frame_regs.svh"
`default_nettype none
module periph_frame
    import periph_frame_pkg::*;
#(
    parameter int PERIPH_ID = 0,
    parameter int N_TASK    = 4,
    parameter int N_EVT     = 4,
    parameter int N_CHAN    = 16,
    parameter int PIN_W     = 5
)
(
    input  wire logic              sys_clk,       // system clock, 10 MHz
    input  wire logic              reset_n,       // async reset
    input  wire logic              ce,            // clock enable, freezes all state
    input  wire logic              reg_wr,        // register write strobe
    input  wire logic              reg_rd,        // register read strobe
    input  wire logic [31:0]       reg_addr,      // byte address
    input  wire logic [31:0]       reg_wdata,     // write data
    output logic      [31:0]       reg_rdata,     // read data
    output logic                   reg_rvalid,    // read data valid
    output logic                   reg_hit,       // address falls in this slot
    input  wire logic [N_TASK-1:0] task_in,       // task signals from own logic
    input  wire logic [N_EVT-1:0]  evt_in,        // event signals from own logic
    output logic      [N_TASK-1:0] task_pulse,    // tasks fired
    input  wire logic [N_CHAN-1:0] chan_in,       // fabric channels in
    output logic      [N_CHAN-1:0] chan_out,      // fabric channels out
    output logic                   irq,           // interrupt line
    output logic      [4:0]        irq_index,     // interrupt number
    output logic                   enabled,       // peripheral enabled
    output logic      [PIN_W-1:0]  pin_sel,       // pin in force
    output logic                   pin_connected  // pin is connected
);

    localparam int CH_W    = (N_CHAN > 1) ? $clog2(N_CHAN) : 1;
    localparam int N_SHORT = (N_EVT < N_TASK) ? N_EVT : N_TASK;
    localparam logic [31:0] BASE = `PERIPH_BASE_ADDR + 32'(PERIPH_ID) * `PERIPH_SLOT_SIZE;

    if (PERIPH_ID < 0 || PERIPH_ID > 31 || N_TASK < 1 || N_TASK > 32 || N_EVT < 1 ||
        N_EVT > 32 || N_CHAN < 2 || N_CHAN > 256 || PIN_W < 1 || PIN_W > 31)
    begin : g_bad_params
        $error("periph_frame: parameter out of range");
    end

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    slot_off_t off;
    logic      wr;
    logic      rd;

    assign reg_hit   = (reg_addr[31:12] == BASE[31:12]);
    assign off       = reg_addr[11:0];
    assign wr        = ce & reg_wr & reg_hit;
    assign rd        = ce & reg_rd & reg_hit;
    assign irq_index = 5'(PERIPH_ID);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic                        enable_r, enable_nxt;
    logic [31:0]                 shorts_r, shorts_nxt;
    logic [N_EVT-1:0]            mask_r, mask_nxt;
    logic [N_EVT-1:0]            events_r, events_nxt;
    logic [N_TASK-1:0]           sub_en_r, sub_en_nxt;
    logic [N_TASK-1:0][CH_W-1:0] sub_ch_r, sub_ch_nxt;
    logic [N_EVT-1:0]            pub_en_r, pub_en_nxt;
    logic [N_EVT-1:0][CH_W-1:0]  pub_ch_r, pub_ch_nxt;
    logic [PIN_W-1:0]            psel_r, psel_nxt;
    logic [N_TASK-1:0]           task_r, task_nxt;
    logic [N_CHAN-1:0]           chan_r, chan_nxt;
    logic                        irq_r, irq_nxt;
    logic [31:0]                 rdata_r, rdata_nxt;
    logic                        rvalid_r, rvalid_nxt;

    logic [N_EVT-1:0]  evt_gen;
    logic [N_EVT-1:0]  evt_zero_wr;
    logic [N_TASK-1:0] task_fire;
    logic              psel_wr;
    logic              pin_load;
    logic              pin_live;

    // ----------------------------------------------------------------
    // per event and per task trigger logic
    // ----------------------------------------------------------------
    for (genvar i = 0; i < N_EVT; i++)
    begin : g_evt
        assign evt_gen[i] = enable_r & evt_in[i];
        assign evt_zero_wr[i] = wr & ~reg_wdata[`TRIGGER_BIT] &
                                (off == `OFF_EVENT_BASE + 12'(4 * i));
    end

    for (genvar i = 0; i < N_TASK; i++)
    begin : g_task
        logic sw_hit;
        logic sub_hit;
        logic short_hit;
        assign sw_hit    = wr & reg_wdata[`TRIGGER_BIT] & (off == `OFF_TASK_BASE + 12'(4 * i));
        assign sub_hit   = sub_en_r[i] & chan_in[sub_ch_r[i]];
        assign short_hit = (i < N_SHORT) ? (shorts_r[i] & evt_gen[i % N_EVT]) : 1'b0;
        assign task_fire[i] = enable_r & (sw_hit | task_in[i] | sub_hit | short_hit);
    end

    // ----------------------------------------------------------------
    // register writes and outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        enable_nxt = enable_r;
        shorts_nxt = shorts_r;
        mask_nxt   = mask_r;
        sub_en_nxt = sub_en_r;
        sub_ch_nxt = sub_ch_r;
        pub_en_nxt = pub_en_r;
        pub_ch_nxt = pub_ch_r;
        psel_nxt   = psel_r;
        chan_nxt   = '0;
        if (wr)
        begin
            case (off)
                `OFF_ENABLE:             enable_nxt = reg_wdata[`ENABLE_BIT];
                `OFF_SHORTCUTS:          shorts_nxt = reg_wdata;
                `OFF_INT_ENABLE_MASK:    mask_nxt = reg_wdata[N_EVT-1:0];
                `OFF_INT_ENABLE_SETTER:  mask_nxt = mask_r | reg_wdata[N_EVT-1:0];
                `OFF_INT_ENABLE_CLEARER: mask_nxt = mask_r & ~reg_wdata[N_EVT-1:0];
                `OFF_PIN_SELECT:         psel_nxt = reg_wdata[PIN_W-1:0];
                default:                 enable_nxt = enable_r;
            endcase
            for (int i = 0; i < N_TASK; i++)
            begin
                if (off == `OFF_SUBSCRIBE_BASE + 12'(4 * i))
                begin
                    sub_en_nxt[i] = reg_wdata[`HOOK_EN_BIT];
                    sub_ch_nxt[i] = reg_wdata[CH_W-1:0];
                end
            end
            for (int i = 0; i < N_EVT; i++)
            begin
                if (off == `OFF_PUBLISH_BASE + 12'(4 * i))
                begin
                    pub_en_nxt[i] = reg_wdata[`HOOK_EN_BIT];
                    pub_ch_nxt[i] = reg_wdata[CH_W-1:0];
                end
            end
        end
        // set wins over a software clear in the same cycle
        events_nxt = evt_gen | (events_r & ~evt_zero_wr);
        for (int i = 0; i < N_EVT; i++)
        begin
            if (evt_gen[i] && pub_en_r[i])
            begin
                chan_nxt[pub_ch_r[i]] = 1'b1;
            end
        end
        task_nxt = task_fire;
        irq_nxt  = |(events_nxt & mask_nxt);
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb
    begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = rd;
        if (rd)
        begin
            case (off)
                `OFF_ENABLE:             rdata_nxt = 32'(enable_r);
                `OFF_SHORTCUTS:          rdata_nxt = shorts_r;
                `OFF_INT_ENABLE_MASK,
                `OFF_INT_ENABLE_SETTER,
                `OFF_INT_ENABLE_CLEARER: rdata_nxt = 32'(mask_r);
                `OFF_PIN_SELECT:         rdata_nxt = 32'(psel_r);
                default:                 rdata_nxt = 32'h0000_0000;
            endcase
            for (int i = 0; i < N_EVT; i++)
            begin
                if (off == `OFF_EVENT_BASE + 12'(4 * i))
                begin
                    rdata_nxt = 32'(events_r[i]);
                end
                if (off == `OFF_PUBLISH_BASE + 12'(4 * i))
                begin
                    rdata_nxt = {pub_en_r[i], 31'(pub_ch_r[i])};
                end
            end
            for (int i = 0; i < N_TASK; i++)
            begin
                if (off == `OFF_SUBSCRIBE_BASE + 12'(4 * i))
                begin
                    rdata_nxt = {sub_en_r[i], 31'(sub_ch_r[i])};
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enable_r <= 1'b0;
            shorts_r <= `SHORTCUTS_RESET;
            mask_r   <= '0;
            events_r <= '0;
            sub_en_r <= '0;
            sub_ch_r <= '0;
            pub_en_r <= '0;
            pub_ch_r <= '0;
            psel_r   <= PIN_W'(`PIN_SELECT_RESET);
            task_r   <= '0;
            chan_r   <= '0;
            irq_r    <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rvalid_r <= 1'b0;
        end
        else if (ce)
        begin
            enable_r <= enable_nxt;
            shorts_r <= shorts_nxt;
            mask_r   <= mask_nxt;
            events_r <= events_nxt;
            sub_en_r <= sub_en_nxt;
            sub_ch_r <= sub_ch_nxt;
            pub_en_r <= pub_en_nxt;
            pub_ch_r <= pub_ch_nxt;
            psel_r   <= psel_nxt;
            task_r   <= task_nxt;
            chan_r   <= chan_nxt;
            irq_r    <= irq_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign task_pulse = task_r;
    assign chan_out   = chan_r;
    assign irq        = irq_r;
    assign reg_rdata  = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign enabled    = enable_r;

    // ----------------------------------------------------------------
    // pin select: applied while disabled or on the enable edge only
    // ----------------------------------------------------------------
    assign psel_wr  = wr & (off == `OFF_PIN_SELECT);
    assign pin_load = ce & ((psel_wr & ~enable_r) | (enable_nxt & ~enable_r));

    pin_select_delay #(
        .PIN_W    (PIN_W)
    ) u_pin (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .ce       (ce),
        .load     (pin_load),
        .sel_in   (psel_nxt),
        .pin_sel  (pin_sel),
        .pin_live (pin_live)
    );

    assign pin_connected = enable_r & pin_live;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_irq_masked_or: assert property (irq == |(events_r & mask_r))
        else $error("interrupt differs from masked event flags");
    a_event_sets: assert property ((ce && evt_gen[0]) |=> events_r[0])
        else $error("generated event did not set its flag");
    a_event_sticky: assert property ((ce && events_r[0] && !evt_zero_wr[0]) |=> events_r[0])
        else $error("event flag cleared without a zero write");
    a_alias_set: assert property ((wr && off == `OFF_INT_ENABLE_SETTER) |=>
        ((mask_r & $past(reg_wdata[N_EVT-1:0])) == $past(reg_wdata[N_EVT-1:0]))
        && ((mask_r & ~$past(reg_wdata[N_EVT-1:0])) == ($past(mask_r) & ~$past(reg_wdata[N_EVT-1:0]))))
        else $error("set alias write misbehaved");
    a_alias_clear: assert property ((wr && off == `OFF_INT_ENABLE_CLEARER) |=>
        (mask_r == ($past(mask_r) & ~$past(reg_wdata[N_EVT-1:0]))))
        else $error("clear alias write misbehaved");
    a_alias_read: assert property ((rd && off == `OFF_INT_ENABLE_CLEARER) |=>
        (reg_rvalid && reg_rdata == 32'($past(mask_r))))
        else $error("clear alias read does not return the mask");
    a_disabled_quiet: assert property ((ce && !enable_r) |=> (task_pulse == '0 && chan_out == '0))
        else $error("trigger passed while disabled");
    a_sw_task: assert property ((ce && enable_r && wr && reg_wdata[0] && off == `OFF_TASK_BASE)
        |=> task_pulse[0])
        else $error("software task write did not fire");
    a_shortcut_fire: assert property ((ce && shorts_r[0] && evt_gen[0]) |=> task_pulse[0])
        else $error("shortcut did not fire its task");
    a_pin_frozen: assert property ((ce && enable_r && psel_wr && pin_live) |=> pin_live)
        else $error("pin selection reloaded while running");

    c_shortcut: cover property (ce && shorts_r[0] && evt_gen[0]);
    c_event_on_set: cover property (ce && events_r[0] && evt_gen[0]);
    c_irq_rise: cover property (!irq ##1 irq);
    c_pin_connect: cover property (!pin_connected ##1 pin_connected);

endmodule // periph_frame
`default_nettype wire

// ### cpu_bus.sv
// processor-side register bus model for one peripheral slot
`timescale 1ns/1ns
`include "periph_frame_regs.svh"
`default_nettype none
module cpu_bus
#(
    parameter int PERIPH_ID = 0
)
(
    input  wire logic        sys_clk,    // system clock
    output logic             reg_wr,     // write strobe
    output logic             reg_rd,     // read strobe
    output logic      [31:0] reg_addr,   // byte address
    output logic      [31:0] reg_wdata,  // write data
    input  wire logic [31:0] reg_rdata,  // read data
    input  wire logic        reg_rvalid  // read data valid
);
    localparam logic [31:0] BASE = `PERIPH_BASE_ADDR + 32'(PERIPH_ID) * `PERIPH_SLOT_SIZE;
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 32'h0000_0000;
        reg_wdata = 32'h0000_0000;
    end
    // released address and data lines show the inverse of the last value, strobes go low
    task automatic drop();
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic wr(input logic [31:0] off, input logic [31:0] v);
        @(negedge sys_clk);
        reg_addr = BASE + off;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        drop();
    endtask
    task automatic rd(input logic [31:0] off, output logic [31:0] v);
        @(negedge sys_clk);
        reg_addr = BASE + off;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        v = reg_rvalid ? reg_rdata : 32'hxxxx_xxxx;
        drop();
    endtask
    // clear then read back so the clear has landed before moving on
    task automatic clr_evt(input int i);
        logic [31:0] v;
        wr(`OFF_EVENT_BASE + 32'(4 * i), 32'h0000_0000);
        rd(`OFF_EVENT_BASE + 32'(4 * i), v);
    endtask
    // only this slot is ever enabled; hand-over disables then masks all
    task automatic retire();
        wr(`OFF_ENABLE, 32'h0000_0000);
        wr(`OFF_INT_ENABLE_CLEARER, 32'hFFFF_FFFF);
    endtask
endmodule // cpu_bus
`default_nettype wire

// ### periph_frame_tb.sv
// self-checking bench for the peripheral register frame
`timescale 1ns/1ns
`include "periph_frame_regs.svh"
`default_nettype none
module periph_frame_tb;
    localparam int ID = 3;
    logic        sys_clk, reset_n, ce, reg_wr, reg_rd, reg_rvalid;
    logic        irq, enabled, pin_connected, hit, in_slot;
    localparam logic [31:0] BASE_EXP = `PERIPH_BASE_ADDR + 32'(ID) * `PERIPH_SLOT_SIZE;
    logic [31:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [3:0]  task_in, evt_in, task_pulse, flags_m, mask_m, sh_m, t, e;
    logic [15:0] chan_in, chan_out, c;
    logic [4:0]  irq_index, pin_sel;
    int          err_count = 0;
    int          checked = 0;
    int          cyc = 0;

    periph_frame #(.PERIPH_ID(ID)) i_periph_frame (.sys_clk(sys_clk), .reset_n(reset_n),
        .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(hit),
        .task_in(task_in), .evt_in(evt_in), .task_pulse(task_pulse), .chan_in(chan_in),
        .chan_out(chan_out), .irq(irq), .irq_index(irq_index), .enabled(enabled),
        .pin_sel(pin_sel), .pin_connected(pin_connected));
    cpu_bus #(.PERIPH_ID(ID)) i_cpu_bus (.sys_clk(sys_clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic step(input logic [3:0] tv, input logic [3:0] ev, input logic [15:0] cv);
        @(negedge sys_clk);
        task_in = tv;
        evt_in = ev;
        chan_in = cv;
        @(negedge sys_clk);
        task_in = 4'h0;
        evt_in = 4'h0;
        chan_in = 16'h0000;
    endtask
    // task i subscribes to channel 8+i, event i publishes on channel i
    function automatic logic [3:0] exp_task(input logic [3:0] tv, ev, input logic [15:0] cv);
        return tv | (ev & sh_m) | cv[11:8];
    endfunction

    // slot decode seen on every strobe, in and out of the slot
    assign in_slot = (reg_addr >= BASE_EXP) && ((reg_addr - BASE_EXP) < `PERIPH_SLOT_SIZE);
    always @(posedge sys_clk)
    begin
        if (reset_n && (reg_wr || reg_rd))
        begin
            chk("reg_hit", 32'(hit), 32'(in_slot));
        end
    end

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            stop_test();
        end
    end
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial
    begin
        reset_n = 1'b0;
        ce = 1'b1;
        task_in = 4'h0;
        evt_in = 4'h0;
        chan_in = 16'h0000;
        flags_m = 4'h0;
        mask_m = 4'h0;
        d = $urandom(38005);
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        chk("pin_sel", 32'(pin_sel), 32'h0000_001F);
        chk("irq_index", 32'(irq_index), 32'(ID));
        i_cpu_bus.wr(`PERIPH_SLOT_SIZE + `OFF_ENABLE, 32'h0000_0001);
        chk("enabled", 32'(enabled), 32'h0000_0000);
        step(4'hF, 4'hF, 16'hFFFF);
        chk("task_pulse", 32'(task_pulse), 32'h0000_0000);
        i_cpu_bus.rd(`OFF_EVENT_BASE, d);
        chk("event", d, 32'h0000_0000);
        i_cpu_bus.wr(`OFF_PIN_SELECT, 32'h0000_0007);
        repeat (3) @(negedge sys_clk);
        chk("pin_sel", 32'(pin_sel), 32'h0000_001F);
        @(negedge sys_clk);
        chk("pin_sel", 32'(pin_sel), 32'h0000_0007);
        i_cpu_bus.wr(`OFF_ENABLE, 32'h0000_0001);
        chk("enabled", 32'(enabled), 32'h0000_0001);
        repeat (4) @(negedge sys_clk);
        i_cpu_bus.wr(`OFF_PIN_SELECT, 32'h0000_0009);
        repeat (6) @(negedge sys_clk);
        chk("pin_sel", 32'(pin_sel), 32'h0000_0007);
        chk("pin_connected", 32'(pin_connected), 32'h0000_0001);
        i_cpu_bus.rd(`OFF_PIN_SELECT, d);
        chk("pin_stored", d, 32'h0000_0009);
        for (int i = 0; i < 4; i++)
        begin
            i_cpu_bus.wr(`OFF_PUBLISH_BASE + 32'(4 * i), 32'h8000_0000 | 32'(i));
            i_cpu_bus.wr(`OFF_SUBSCRIBE_BASE + 32'(4 * i), 32'h8000_0008 + 32'(i));
        end
        // set, clear, set again, plain write; every alias must read back the mask
        for (int j = 0; j < 4; j++)
        begin
            d = (j == 2) ? 32'h0000_0005 : (j == 3) ? 32'h0000_000D : $urandom;
            i_cpu_bus.wr((j == 3) ? `OFF_INT_ENABLE_MASK : j[0] ? `OFF_INT_ENABLE_CLEARER :
                         `OFF_INT_ENABLE_SETTER, d);
            mask_m = (j == 3) ? d[3:0] : j[0] ? (mask_m & ~d[3:0]) : (mask_m | d[3:0]);
            for (int k = 0; k < 3; k++)
            begin
                i_cpu_bus.rd(`OFF_INT_ENABLE_MASK + 32'(4 * k), d);
                chk("mask", d, 32'(mask_m));
            end
        end
        sh_m = 4'($urandom) | 4'h1;
        i_cpu_bus.wr(`OFF_SHORTCUTS, 32'(sh_m));
        for (int i = 0; i < 4; i++)
        begin
            i_cpu_bus.wr(`OFF_TASK_BASE + 32'(4 * i), 32'h0000_0001);
            chk("task_write", 32'(task_pulse), 32'h0000_0001 << i);
        end
        // clock enable low: nothing is taken, outputs hold
        ce = 1'b0;
        step(4'hF, 4'hF, 16'hFFFF);
        ce = 1'b1;
        chk("task_frozen", 32'(task_pulse), 32'h0000_0008);
        i_cpu_bus.rd(`OFF_EVENT_BASE, d);
        chk("event_frozen", d, 32'h0000_0000);
        for (int n = 0; n < 300; n++)
        begin
            t = 4'($urandom);
            e = (n < 4) ? 4'h1 << n : 4'($urandom);
            c = 16'($urandom);
            step(t, e, c);
            flags_m = flags_m | e;
            chk("task_pulse", 32'(task_pulse), 32'(exp_task(t, e, c)));
            chk("chan_out", 32'(chan_out), 32'(e));
            chk("irq", 32'(irq), 32'(|(flags_m & mask_m)));
        end
        for (int i = 0; i < 4; i++)
        begin
            i_cpu_bus.wr(`OFF_EVENT_BASE + 32'(4 * i), 32'h0000_0001);
            i_cpu_bus.rd(`OFF_EVENT_BASE + 32'(4 * i), d);
            chk("event", d, 32'(flags_m[i]));
            i_cpu_bus.clr_evt(i);
            flags_m[i] = 1'b0;
            i_cpu_bus.rd(`OFF_EVENT_BASE + 32'(4 * i), d);
            chk("event_clr", d, 32'h0000_0000);
            chk("irq", 32'(irq), 32'(|(flags_m & mask_m)));
        end
        i_cpu_bus.retire();
        i_cpu_bus.rd(`OFF_INT_ENABLE_MASK, d);
        chk("mask", d, 32'h0000_0000);
        chk("pin_connected", 32'(pin_connected), 32'h0000_0000);
        step(4'hF, 4'hF, 16'hFFFF);
        chk("task_pulse", 32'(task_pulse), 32'h0000_0000);
        chk("chan_out", 32'(chan_out), 32'h0000_0000);
        stop_test();
    end
endmodule // periph_frame_tb
`default_nettype wire
